// ### dv/sfr_host_model.sv
// Processor-side model that reaches the timer registers over the register bus.
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
    input wire logic mclk, // System clock.
    input wire logic [7:0] sfr_rdata, // Read data from the unit.
    output logic [7:0] sfr_addr, // Byte or bit address.
    output logic [7:0] sfr_wdata, // Byte write data.
    output logic sfr_we, // Byte write strobe.
    output logic sfr_bit_we, // Bit write strobe.
    output logic sfr_bit_wdata // Bit write value.
);
    // The bus idles on an unmapped address so nothing lands during reset.
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_we = 1'h0;
        sfr_bit_we = 1'h0;
        sfr_bit_wdata = 1'h0;
    end
    // Byte write; data is inverted afterwards so nothing relies on a stale value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_we <= 1'h1;
        @(negedge mclk);
        sfr_we <= 1'h0;
        sfr_wdata <= ~d;
    endtask : wr
    // Single-bit write of one control bit.
    task automatic bwr(input logic [7:0] a, input logic v);
        @(negedge mclk);
        sfr_addr <= a;
        sfr_bit_wdata <= v;
        sfr_bit_we <= 1'h1;
        @(negedge mclk);
        sfr_bit_we <= 1'h0;
        sfr_bit_wdata <= ~v;
    endtask : bwr
    // Read; the registered data is taken one full cycle after the address.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_addr <= a;
        @(negedge mclk);
        d = sfr_rdata;
    endtask : rd
endmodule : sfr_host_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the dual timer unit driven through a host model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic mclk, reset_n, gate_first, count_first, gate_second, count_second;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic sfr_we, sfr_bit_we, sfr_bit_wdata;
    logic [3:0] control_low_nibble;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    dual_timer_counter_unit i_dual_timer_counter_unit (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_bit_we(sfr_bit_we), .sfr_bit_wdata(sfr_bit_wdata),
        .sfr_rdata(sfr_rdata), .gate_input_pin_first(gate_first), .gate_input_pin_second(gate_second),
        .count_input_pin_first(count_first), .count_input_pin_second(count_second),
        .control_low_nibble(control_low_nibble));
    sfr_host_model i_sfr_host_model (.mclk(mclk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_bit_we(sfr_bit_we), .sfr_bit_wdata(sfr_bit_wdata));
    // Free-running clock and cycle counter for elapsed-time checks.
    always #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    // Stops timers, then loads mode, clock control and timer 0 bytes.
    task automatic arm(input logic [7:0] md, input logic [7:0] ck, input logic [7:0] th, input logic [7:0] tl);
        i_sfr_host_model.wr(8'h88, 8'h00);
        i_sfr_host_model.wr(8'h89, md);
        i_sfr_host_model.wr(8'h8E, ck);
        i_sfr_host_model.wr(8'h8C, th);
        i_sfr_host_model.wr(8'h8A, tl);
    endtask : arm
    // Sets a run bit, polls for the flag under a bound, then stops the timer.
    task automatic go(input logic [7:0] ba, input int pos, output int n);
        logic [7:0] d;
        int t0;
        i_sfr_host_model.bwr(ba, 1'h1);
        t0 = cyc;
        d = 8'h00;
        for (int i = 0; i < 60 && d[pos] !== 1'h1; i++) i_sfr_host_model.rd(8'h88, d);
        n = cyc - t0;
        i_sfr_host_model.bwr(ba, 1'h0);
        `CHK("overflow_flag", 1'h1, d[pos])
    endtask : go
    // Reads a byte and compares it.
    task automatic expect_byte(input logic [7:0] a, input logic [7:0] ex);
        logic [7:0] d;
        i_sfr_host_model.rd(a, d);
        `CHK("sfr_byte", ex, d)
    endtask : expect_byte
    // Timer 0 in 16-bit mode at the slow divider; three ticks to overflow.
    task automatic t_mode1;
        int n;
        arm(8'h01, 8'h00, 8'hFF, 8'hFD);
        go(8'h8C, 5, n);
        `CHK("slow_elapsed", 1'h1, n >= 20)
        expect_byte(8'h8C, 8'h00);
        expect_byte(8'h8A, 8'h00);
        i_sfr_host_model.bwr(8'h8D, 1'h0);
        expect_byte(8'h88, 8'h00);
        $display("Test mode1 done");
    endtask : t_mode1
    // 13-bit mode at the fast divider; upper low-byte bits do not count.
    task automatic t_mode0;
        int n;
        arm(8'h00, 8'h08, 8'hFF, 8'hFD);
        go(8'h8C, 5, n);
        `CHK("fast_elapsed", 1'h1, n <= 16)
        expect_byte(8'h8C, 8'h00);
        expect_byte(8'h8A, 8'h00);
        $display("Test mode0 done");
    endtask : t_mode0
    // Auto-reload: low byte reloads from the untouched high byte.
    task automatic t_mode2;
        int n;
        arm(8'h02, 8'h08, 8'hFD, 8'hFD);
        go(8'h8C, 5, n);
        expect_byte(8'h8A, 8'hFD);
        expect_byte(8'h8C, 8'hFD);
        $display("Test mode2 done");
    endtask : t_mode2
    // Split mode: high byte runs on timer 1 bits; real timer 1 runs free.
    task automatic t_split;
        int n;
        logic [7:0] d1, d2;
        arm(8'h13, 8'h08, 8'hFD, 8'h40);
        go(8'h8E, 7, n);
        expect_byte(8'h8C, 8'h00);
        expect_byte(8'h8A, 8'h40);
        expect_byte(8'h88, 8'h80);
        i_sfr_host_model.rd(8'h8B, d1);
        repeat (40) @(negedge mclk);
        i_sfr_host_model.rd(8'h8B, d2);
        `CHK("free_run", 1'h1, d1 !== d2)
        $display("Test split done");
    endtask : t_split
    // Timer 1 runs on its run bit, then halts and holds in mode 3.
    task automatic t_halt;
        logic [7:0] d1, d2;
        arm(8'h10, 8'h10, 8'h00, 8'h00);
        i_sfr_host_model.bwr(8'h8E, 1'h1);
        i_sfr_host_model.rd(8'h8B, d1);
        repeat (20) @(negedge mclk);
        i_sfr_host_model.rd(8'h8B, d2);
        `CHK("t1_runs", 1'h1, d1 !== d2)
        i_sfr_host_model.wr(8'h89, 8'h30);
        i_sfr_host_model.rd(8'h8B, d1);
        repeat (20) @(negedge mclk);
        i_sfr_host_model.rd(8'h8B, d2);
        `CHK("t1_hold", d1, d2)
        $display("Test halt done");
    endtask : t_halt
    // Pin pulses on both count pins, long enough for the synchroniser.
    task automatic pulse(input int k);
        repeat (k) begin
            @(negedge mclk);
            count_first <= 1'h1;
            count_second <= 1'h1;
            repeat (3) @(negedge mclk);
            count_first <= 1'h0;
            count_second <= 1'h0;
            repeat (3) @(negedge mclk);
        end
    endtask : pulse
    // Gated counters on both timers: pulses count only while the gate pin is high.
    task automatic t_count;
        arm(8'hDD, 8'h00, 8'h00, 8'h00);
        i_sfr_host_model.wr(8'h8B, 8'h00);
        i_sfr_host_model.bwr(8'h8C, 1'h1);
        i_sfr_host_model.bwr(8'h8E, 1'h1);
        pulse(3);
        expect_byte(8'h8A, 8'h00);
        expect_byte(8'h8B, 8'h00);
        @(negedge mclk);
        gate_first <= 1'h1;
        gate_second <= 1'h1;
        pulse(3);
        expect_byte(8'h8A, 8'h03);
        expect_byte(8'h8B, 8'h03);
        $display("Test count done");
    endtask : t_count
    // Low nibble output, bit writes and an unmapped read.
    task automatic t_ctrl;
        i_sfr_host_model.wr(8'h88, 8'h0A);
        @(negedge mclk);
        `CHK("low_nibble", 4'hA, control_low_nibble)
        i_sfr_host_model.bwr(8'h8F, 1'h1);
        expect_byte(8'h88, 8'h8A);
        i_sfr_host_model.bwr(8'h8F, 1'h0);
        expect_byte(8'h88, 8'h0A);
        expect_byte(8'h90, 8'h00);
        $display("Test ctrl done");
    endtask : t_ctrl
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("Checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        final_report();
    end
    // Main sequence.
    initial begin
        mclk = 1'h0;
        reset_n = 1'h0;
        gate_first = 1'h0;
        count_first = 1'h0;
        gate_second = 1'h0;
        count_second = 1'h0;
        repeat (10) @(negedge mclk);
        reset_n = 1'h1;
        repeat (3) @(posedge mclk);
        t_mode1();
        t_mode0();
        t_mode2();
        t_split();
        t_halt();
        t_count();
        t_ctrl();
        final_report();
    end
endmodule : tb_top
`default_nettype wire

// ### logic/dual_timer_counter_unit.sv
// Two timer/counters with control, mode and clock control registers on the register bus.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_unit (
    input wire logic mclk, // System clock, one oscillator period per edge.
    input wire logic reset_n, // Asynchronous active-low reset.
    input wire logic [7:0] sfr_addr, // Byte or bit address.
    input wire logic [7:0] sfr_wdata, // Byte write data.
    input wire logic sfr_we, // Byte write strobe.
    input wire logic sfr_bit_we, // Single-bit write strobe.
    input wire logic sfr_bit_wdata, // Single-bit write value.
    output logic [7:0] sfr_rdata, // Read data of addressed byte.
    input wire logic gate_input_pin_first, // Timer 0 gate pin, high allows counting.
    input wire logic gate_input_pin_second, // Timer 1 gate pin.
    input wire logic count_input_pin_first, // Timer 0 count pin.
    input wire logic count_input_pin_second, // Timer 1 count pin.
    output logic [3:0] control_low_nibble // Interrupt-logic bits of control register.
);
    // State of the block apart from the reset synchroniser, registered as one word.
    typedef struct packed {
        logic [7:0] ctrl; // Control and status register.
        logic [7:0] mode; // Mode register.
        logic [7:0] clk_ctrl; // Clock control register.
        logic [7:0] low_first; // Timer 0 low byte.
        logic [7:0] high_first; // Timer 0 high byte.
        logic [7:0] low_second; // Timer 1 low byte.
        logic [7:0] high_second; // Timer 1 high byte.
        logic [3:0] div0; // Prescale counter of timer 0.
        logic [3:0] div1; // Prescale counter of timer 1.
        logic [1:0] cnt_s0; // Pin synchroniser timer 0.
        logic [1:0] cnt_s1; // Pin synchroniser timer 1.
        logic prev0; // Synchronised pin 0, previous sample.
        logic prev1; // Synchronised pin 1, previous sample.
        logic [7:0] rdata; // Registered read data.
    } state_s;

    state_s st_reg; // Current state.
    state_s st_next; // Next state.
    logic rst_m; // First reset release stage.
    logic rst_s; // Synchronised reset used by the rest of the block.

    // Reset release synchroniser.
    // Assertion stays asynchronous so the block is quiet at once,
    // while release is aligned to the clock to avoid a split first edge.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // Per-timer decoded controls.
    logic [3:0] nib0; // Timer 0 mode nibble.
    logic [3:0] nib1; // Timer 1 mode nibble.
    logic tick0; // Timer 0 divided tick.
    logic tick1; // Timer 1 divided tick.
    logic fall0; // Falling edge seen on count pin 0.
    logic fall1; // Falling edge seen on count pin 1.
    logic en0; // Timer 0 low part increments.
    logic en1; // Timer 1 increments.
    logic en0h; // Split high byte increments.
    logic en1r; // Timer 1 raw increment source.
    logic [1:0] md0; // Timer 0 mode.
    logic [1:0] md1; // Timer 1 mode.
    logic ovf0; // Timer 0 overflow this cycle.
    logic ovf1; // Timer 1 overflow this cycle.
    logic [7:0] bit_mask; // One-hot mask of the addressed control bit.

    // Next-state logic: prescalers, edge detection, counting and register writes.
    // Everything but the read data is computed from st_reg so that the order of the blocks
    // below only matters where a later write must win over an earlier one.
    always_comb begin
        st_next = st_reg;
        nib0 = st_reg.mode[3:0]; // [RULE_17]
        nib1 = st_reg.mode[7:4]; // [RULE_17]
        md0 = nib0[1:0]; // [RULE_02]
        md1 = nib1[1:0]; // [RULE_02]
        // Prescalers wrap at 12 or 4 periods. [RULE_04] [RULE_18]
        // A switch from slow to fast with a high count ticks at once; that
        // costs one short period but never stalls the timer.
        tick0 = (st_reg.div0 >= ((st_reg.clk_ctrl[dual_timer_pkg::T0SEL_POS]) ? dual_timer_pkg::DIV_FAST
                 : dual_timer_pkg::DIV_SLOW) - 4'h1);
        tick1 = (st_reg.div1 >= ((st_reg.clk_ctrl[dual_timer_pkg::T1SEL_POS]) ? dual_timer_pkg::DIV_FAST
                 : dual_timer_pkg::DIV_SLOW) - 4'h1);
        st_next.div0 = tick0 ? 4'h0 : st_reg.div0 + 4'h1;
        st_next.div1 = tick1 ? 4'h0 : st_reg.div1 + 4'h1;
        // Only the second synchroniser stage feeds the edge detector. [RULE_19]
        // The previous sample resets low, the idle level a released pin
        // would not have, so no false edge can follow reset.
        st_next.cnt_s0 = {st_reg.cnt_s0[0], count_input_pin_first};
        st_next.cnt_s1 = {st_reg.cnt_s1[0], count_input_pin_second};
        st_next.prev0 = st_reg.cnt_s0[1];
        st_next.prev1 = st_reg.cnt_s1[1];
        fall0 = st_reg.prev0 && !st_reg.cnt_s0[1]; // [RULE_19]
        fall1 = st_reg.prev1 && !st_reg.cnt_s1[1]; // [RULE_19]
        // Increment source and gating for timer 0 low part. [RULE_01] [RULE_03] [RULE_14] [RULE_16]
        // The low control nibble takes no part in any enable.
        en0 = st_reg.ctrl[dual_timer_pkg::RUN_FIRST_POS]
              && (!nib0[dual_timer_pkg::GATE_POS] || gate_input_pin_first)
              && (nib0[dual_timer_pkg::CT_POS] ? fall0 : tick0);
        // Split high byte runs from timer 1 run bit on the internal tick. [RULE_10]
        en0h = st_reg.ctrl[dual_timer_pkg::RUN_SECOND_POS] && tick0;
        // Timer 1 free-runs under split, halts in its own mode 3. [RULE_11] [RULE_12] [RULE_14] [RULE_03] [RULE_01]
        en1r = (nib1[dual_timer_pkg::CT_POS] ? fall1 : tick1);
        en1 = (md1 != dual_timer_pkg::MODE_SPLIT) && en1r && ((md0 == dual_timer_pkg::MODE_SPLIT)
              || (st_reg.ctrl[dual_timer_pkg::RUN_SECOND_POS]
              && (!nib1[dual_timer_pkg::GATE_POS] || gate_input_pin_second)));
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        // Timer 0 counting by mode.
        if (en0) begin
            case (md0)
                dual_timer_pkg::MODE_13BIT: begin
                    // Upper three low-byte bits are cleared as the counter runs.
                    st_next.low_first = {3'h0, st_reg.low_first[4:0] + 5'h1}; // [RULE_05]
                    if (st_reg.low_first[4:0] == dual_timer_pkg::LOW5_MAX) begin
                        st_next.high_first = st_reg.high_first + 8'h01; // [RULE_05]
                        ovf0 = (st_reg.high_first == dual_timer_pkg::BYTE_MAX); // [RULE_06]
                    end
                end
                dual_timer_pkg::MODE_16BIT: begin
                    // Full sixteen bits, low byte carries into high byte.
                    st_next.low_first = st_reg.low_first + 8'h01; // [RULE_07]
                    if (st_reg.low_first == dual_timer_pkg::BYTE_MAX) begin
                        st_next.high_first = st_reg.high_first + 8'h01;
                        ovf0 = (st_reg.high_first == dual_timer_pkg::BYTE_MAX); // [RULE_07]
                    end
                end
                dual_timer_pkg::MODE_RELOAD: begin
                    // High byte is the reload value and is never changed here.
                    if (st_reg.low_first == dual_timer_pkg::BYTE_MAX) begin
                        st_next.low_first = st_reg.high_first; // [RULE_08]
                        ovf0 = 1'b1;
                    end else begin
                        st_next.low_first = st_reg.low_first + 8'h01;
                    end
                end
                default: begin
                    // Split mode: the low byte is an 8-bit counter on its own.
                    st_next.low_first = st_reg.low_first + 8'h01; // [RULE_09]
                    ovf0 = (st_reg.low_first == dual_timer_pkg::BYTE_MAX);
                end
            endcase
        end
        // Split mode high byte of timer 0 flags timer 1's overflow. [RULE_09] [RULE_10]
        if ((md0 == dual_timer_pkg::MODE_SPLIT) && en0h) begin
            st_next.high_first = st_reg.high_first + 8'h01;
            ovf1 = (st_reg.high_first == dual_timer_pkg::BYTE_MAX);
        end
        // Timer 1 counting; its overflow flag is taken by timer 0 in split mode.
        // While split, timer 1 still counts but can no longer raise its flag,
        // which is the price of lending its control bits to the high byte.
        if (en1) begin
            case (md1)
                dual_timer_pkg::MODE_13BIT: begin
                    // Thirteen-bit count, as for timer 0.
                    st_next.low_second = {3'h0, st_reg.low_second[4:0] + 5'h1}; // [RULE_05]
                    if (st_reg.low_second[4:0] == dual_timer_pkg::LOW5_MAX) begin
                        st_next.high_second = st_reg.high_second + 8'h01;
                        if (md0 != dual_timer_pkg::MODE_SPLIT) begin
                            ovf1 = (st_reg.high_second == dual_timer_pkg::BYTE_MAX); // [RULE_06]
                        end
                    end
                end
                dual_timer_pkg::MODE_16BIT: begin
                    // Sixteen-bit count, as for timer 0.
                    st_next.low_second = st_reg.low_second + 8'h01; // [RULE_07]
                    if (st_reg.low_second == dual_timer_pkg::BYTE_MAX) begin
                        st_next.high_second = st_reg.high_second + 8'h01;
                        if (md0 != dual_timer_pkg::MODE_SPLIT) begin
                            ovf1 = (st_reg.high_second == dual_timer_pkg::BYTE_MAX);
                        end
                    end
                end
                default: begin
                    // Auto-reload; mode 3 never reaches here because en1 is low.
                    if (st_reg.low_second == dual_timer_pkg::BYTE_MAX) begin
                        st_next.low_second = st_reg.high_second; // [RULE_08]
                        if (md0 != dual_timer_pkg::MODE_SPLIT) begin
                            ovf1 = 1'b1;
                        end
                    end else begin
                        st_next.low_second = st_reg.low_second + 8'h01;
                    end
                end
            endcase
        end
        // Byte writes from software override counting in the same cycle. [RULE_20]
        if (sfr_we) begin
            case (sfr_addr)
                dual_timer_pkg::ADDR_CONTROL: st_next.ctrl = sfr_wdata;
                dual_timer_pkg::ADDR_MODE: st_next.mode = sfr_wdata;
                dual_timer_pkg::ADDR_LOW_FIRST: st_next.low_first = sfr_wdata;
                dual_timer_pkg::ADDR_LOW_SECOND: st_next.low_second = sfr_wdata;
                dual_timer_pkg::ADDR_HIGH_FIRST: st_next.high_first = sfr_wdata;
                dual_timer_pkg::ADDR_HIGH_SECOND: st_next.high_second = sfr_wdata;
                dual_timer_pkg::ADDR_CLOCK_CONTROL: st_next.clk_ctrl = sfr_wdata;
                default: ; // Unmapped addresses are ignored.
            endcase
        end
        // Single-bit write touches only the addressed control bit. [RULE_15]
        bit_mask = 8'h01 << sfr_addr[2:0];
        if (sfr_bit_we && (sfr_addr[7:3] == dual_timer_pkg::BIT_BASE_CONTROL[7:3])) begin
            st_next.ctrl = sfr_bit_wdata ? (st_reg.ctrl | bit_mask) : (st_reg.ctrl & ~bit_mask);
        end
        // Hardware set wins over a software clear in the same cycle. [RULE_13] [RULE_20]
        // Losing an overflow would hide an event, a late clear costs nothing.
        if (ovf0) begin
            st_next.ctrl[dual_timer_pkg::FLAG_FIRST_POS] = 1'b1;
        end
        if (ovf1) begin
            st_next.ctrl[dual_timer_pkg::FLAG_SECOND_POS] = 1'b1;
        end
        // Registered read data; unmapped addresses read zero.
        // It shows the value after this cycle's updates, one cycle late.
        case (sfr_addr)
            dual_timer_pkg::ADDR_CONTROL: st_next.rdata = st_next.ctrl;
            dual_timer_pkg::ADDR_MODE: st_next.rdata = st_next.mode;
            dual_timer_pkg::ADDR_LOW_FIRST: st_next.rdata = st_next.low_first;
            dual_timer_pkg::ADDR_LOW_SECOND: st_next.rdata = st_next.low_second;
            dual_timer_pkg::ADDR_HIGH_FIRST: st_next.rdata = st_next.high_first;
            dual_timer_pkg::ADDR_HIGH_SECOND: st_next.rdata = st_next.high_second;
            dual_timer_pkg::ADDR_CLOCK_CONTROL: st_next.rdata = st_next.clk_ctrl;
            default: st_next.rdata = dual_timer_pkg::RESET_BYTE;
        endcase
    end

    // State register; the whole block clears on reset.
    always_ff @(posedge mclk or negedge rst_s) begin
        if (!rst_s) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Data outputs come straight from the state register.
    assign sfr_rdata = st_reg.rdata;
    assign control_low_nibble = st_reg.ctrl[3:0];

    // Checks of the counting behaviour.
    a_run_stops0: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_14]
        (!st_reg.ctrl[dual_timer_pkg::RUN_FIRST_POS] && !sfr_we) |=> (st_reg.low_first == $past(st_reg.low_first)))
        else $error("timer 0 low byte moved while stopped");
    a_gate_blocks0: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_03]
        (st_reg.mode[dual_timer_pkg::GATE_POS] && !gate_input_pin_first && !sfr_we) |=>
        (st_reg.low_first == $past(st_reg.low_first)))
        else $error("timer 0 counted with gate low");
    a_flag_sets0: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_13]
        ovf0 |=> st_reg.ctrl[dual_timer_pkg::FLAG_FIRST_POS])
        else $error("timer 0 overflow flag not set");
    a_flag_sets1: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_20]
        ovf1 |=> st_reg.ctrl[dual_timer_pkg::FLAG_SECOND_POS])
        else $error("timer 1 overflow flag lost");
    a_mode3_halt1: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_12]
        (md1 == dual_timer_pkg::MODE_SPLIT && !sfr_we) |=> $stable(st_reg.low_second))
        else $error("timer 1 counted in mode 3");
    a_reload_high: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_08]
        (en0 && md0 == dual_timer_pkg::MODE_RELOAD && st_reg.low_first == dual_timer_pkg::BYTE_MAX && !sfr_we)
        |=> (st_reg.low_first == $past(st_reg.high_first)))
        else $error("auto-reload value wrong");
    a_mode0_top: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_05]
        (md0 == dual_timer_pkg::MODE_13BIT && !sfr_we)
        |=> (st_reg.low_first[7:5] == 3'h0 || $past(st_reg.low_first[7:5]) != 3'h0))
        else $error("mode 0 low byte exceeded five bits");
    // A later switch to the fast divider may legally tick sooner.
    a_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_04]
        (tick0 && !st_reg.clk_ctrl[dual_timer_pkg::T0SEL_POS])
        |=> (!tick0 || st_reg.clk_ctrl[dual_timer_pkg::T0SEL_POS]) [*8])
        else $error("divide by 12 ticks too close");
    a_edge_count: assert property (@(posedge mclk) disable iff (!rst_s) // [RULE_19]
        (fall0 && st_reg.mode[dual_timer_pkg::CT_POS] && st_reg.ctrl[dual_timer_pkg::RUN_FIRST_POS]
         && !st_reg.mode[dual_timer_pkg::GATE_POS] && md0 == dual_timer_pkg::MODE_16BIT && !sfr_we)
        |=> (st_reg.low_first == $past(st_reg.low_first) + 8'h01))
        else $error("count pin edge missed");
    // Main scenarios that the bench is expected to reach.
    c_ovf0: cover property (@(posedge mclk) disable iff (!rst_s) ovf0);
    c_split: cover property (@(posedge mclk) disable iff (!rst_s) en0h && md0 == dual_timer_pkg::MODE_SPLIT);
    c_reload: cover property (@(posedge mclk) disable iff (!rst_s) en0 && md0 == dual_timer_pkg::MODE_RELOAD);
    c_pin_count: cover property (@(posedge mclk) disable iff (!rst_s) en1 && nib1[dual_timer_pkg::CT_POS]);
    c_halt: cover property (@(posedge mclk) disable iff (!rst_s) en1r && md1 == dual_timer_pkg::MODE_SPLIT);
endmodule : dual_timer_counter_unit
`default_nettype wire

// ### logic/dual_timer_pkg.sv
// Package with register addresses, field positions and timing constants for the dual timer unit.
// Function
// RULE_01: Select bit picks divided clock or pin.
// RULE_02: Two-bit mode field selects four modes.
// RULE_03: Gate bit adds gate pin condition.
// RULE_04: Timer ticks every 4 or 12 periods.
// RULE_05: Mode 0 is five plus eight bits.
// RULE_06: Mode 0 flags overflow from 01FFF.
// RULE_07: Mode 1 is a 16-bit counter.
// RULE_08: Mode 2 reloads low from high byte.
// RULE_09: Split mode gives two 8-bit counters.
// RULE_10: Split high byte uses timer 1 bits.
// RULE_11: Split mode makes timer 1 free-run.
// RULE_12: Timer 1 in mode 3 halts.
// RULE_13: Hardware sets both overflow flags.
// RULE_14: Run bits 6 and 4 enable timers.
// RULE_15: Control register is bit-addressable.
// RULE_16: Low control nibble ignored by timers.
// RULE_17: Mode register: timer 1 upper nibble.
// RULE_18: Clock-select 0 divides 12, 1 divides 4.
// RULE_19: Count pin synchronised, falling edges count.
// RULE_20: Software writes work; hardware set wins.
package dual_timer_pkg;
    // Byte addresses on the special function register bus.
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_LOW_FIRST = 8'h8A;
    localparam logic [7:0] ADDR_LOW_SECOND = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_FIRST = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_SECOND = 8'h8D;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
    // Bit addresses of the control register; bit n is at base plus n.
    localparam logic [7:0] BIT_BASE_CONTROL = 8'h88;
    localparam logic [4:0] BIT_PAGE_MASK = 5'h1F;
    // Control register field positions.
    localparam int RUN_FIRST_POS = 4;
    localparam int FLAG_FIRST_POS = 5;
    localparam int RUN_SECOND_POS = 6;
    localparam int FLAG_SECOND_POS = 7;
    // Mode nibble field positions, relative to the nibble.
    localparam int GATE_POS = 3;
    localparam int CT_POS = 2;
    localparam int NIBBLE_SECOND = 4;
    // Clock control field positions.
    localparam int T0SEL_POS = 3;
    localparam int T1SEL_POS = 4;
    // Mode encodings.
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // Tick dividers in oscillator periods.
    localparam logic [3:0] DIV_SLOW = 4'hC;
    localparam logic [3:0] DIV_FAST = 4'h4;
    // Reset value and counter maxima.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] LOW5_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage : dual_timer_pkg
